// File: bench/flrpc_flash_model.sv
// behavioural flash array answering the controller's read and program strobes
module flrpc_flash_model (
	input  wire logic        clk,
	input  wire logic        fl_rd_q,
	input  wire logic        fl_prog_q,
	input  wire logic [31:0] fl_addr_q,
	input  wire logic [31:0] fl_wdata_q,
	input  wire logic [1:0]  fl_wsize_q,
	output logic      [63:0] fl_rdata,
	output logic             fl_prog_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [63:0] mem [int];  // programmed blocks only
	logic [63:0] b;          // block being merged
	logic [31:0] cyc = '0;   // idle pattern, moves every cycle
	int          n = 0;      // program wait counter
	// untouched blocks: upper half of each 8 KB is erased, the rest holds a pattern
	function automatic logic [63:0] blk(int i);
		return mem.exists(i) ? mem[i] : (i[9] ? '1 : {i ^ 32'h0f0f_0f0f, i});
	endfunction
	// outside a strobe the data lines wander so a stale sample cannot pass
	assign fl_rdata = fl_rd_q ? blk(int'(fl_addr_q[31:3])) : {cyc, ~cyc};
	initial fl_prog_done = 1'b0;
	// slow array: three cycles per program, lanes merged at completion
	always @(posedge clk) begin
		cyc <= cyc + 32'h1357_9bdf;
		fl_prog_done <= 1'b0;
		if (fl_prog_q && !fl_prog_done) begin
			n = n + 1;
			if (n == 3) begin
				n = 0;
				fl_prog_done <= 1'b1;
				b = blk(int'(fl_addr_q[31:3]));
				for (int k = 0; k < (1 << fl_wsize_q); k++) b[8*(fl_addr_q[2:0]+k)+:8] = fl_wdata_q[8*(fl_addr_q[1:0]+k)+:8];
				mem[int'(fl_addr_q[31:3])] = b;
			end
		end
	end
endmodule

// File: bench/tb.sv
// self-checking bench for the flash read and program controller
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import flrpc_pkg::*;
	logic clk = 0, rst = 1, low_power = 0, access_ctrl_wr = 0, key_wr = 0, bank_ctrl_wr = 0, bank_ctrl_prog = 0;
	logic bank_ctrl_lock = 0, cipher_en = 0, ext_sel = 0, cipher_range_wr = 0, if_req = 0, d_req = 0, d_write = 0;
	logic key_err_q, if_valid_q, d_done_q, d_err_q, fl_rd_q, fl_prog_q, fl_prog_done, spi_sck_q, spi_cs_n_q;
	logic [ACC_W-1:0]  access_ctrl_wdata = '0, access_ctrl_q;
	logic [BANK_W-1:0] key_bank = '0, bank_ctrl_bank = '0;
	logic [31:0]       key_data = '0, cipher_range_wdata = '0, if_addr = '0, d_addr = '0, d_wdata = '0;
	logic [31:0]       if_rdata_q, d_rdata_q, fl_addr_q, fl_wdata_q, rd, wa, wd, a;
	logic [2:0]        fail_clr = '0, bank_locked_q, prog_enabled_q, busy_flag_q, prog_fail_q;
	logic [1:0]        d_size = '0, fl_wsize_q;
	logic [63:0]       fl_rdata;
	logic [63:0]       em [int];  // expected array contents
	logic              de, busy_seen = 0;
	int                num_errors = 0, n_tests = 0, n;
	flrpc_ctrl dut (.clk, .rst, .low_power, .access_ctrl_wr, .access_ctrl_wdata, .access_ctrl_q, .key_wr, .key_bank,
		.key_data, .bank_ctrl_wr, .bank_ctrl_bank, .bank_ctrl_prog, .bank_ctrl_lock, .fail_clr, .cipher_en, .ext_sel,
		.cipher_range_wr, .cipher_range_wdata, .key_err_q, .bank_locked_q, .prog_enabled_q, .busy_flag_q, .prog_fail_q,
		.if_req, .if_addr, .if_valid_q, .if_rdata_q, .d_req, .d_write, .d_size, .d_addr, .d_wdata, .d_done_q, .d_err_q,
		.d_rdata_q, .fl_rd_q, .fl_prog_q, .fl_addr_q, .fl_wdata_q, .fl_wsize_q, .fl_rdata, .fl_prog_done, .spi_sck_q,
		.spi_cs_n_q);
	flrpc_flash_model fm (.clk, .fl_rd_q, .fl_prog_q, .fl_addr_q, .fl_wdata_q, .fl_wsize_q, .fl_rdata, .fl_prog_done);
	always #25 clk = ~clk;  // never stops, also during programming
	// a fetch answer must never appear while a bank is busy programming
	always @(negedge clk) begin
		if (busy_flag_q[0] === 1'b1) busy_seen = 1;
		if (if_valid_q === 1'b1 && busy_flag_q !== 3'b000) begin
			num_errors++;
			$display("MISMATCH fetch_while_busy exp 0 got 1");
		end
	end
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	function automatic logic [63:0] eblk(int i);
		return em.exists(i) ? em[i] : (i[9] ? '1 : {i ^ 32'h0f0f_0f0f, i});
	endfunction
	function automatic logic [31:0] ew(logic [31:0] ad);
		logic [63:0] b;
		b = eblk(int'(ad[31:3]));
		return b[32*ad[2]+:32];
	endfunction
	// mirror a successful program into the expected contents
	task automatic put(logic [31:0] ad, logic [1:0] s, logic [31:0] w);
		logic [63:0] b;
		b = eblk(int'(ad[31:3]));
		for (int k = 0; k < (1 << s); k++) b[8*(ad[2:0]+k)+:8] = w[8*(ad[1:0]+k)+:8];
		em[int'(ad[31:3])] = b;
	endtask
	// data bus cycle; lp > 0 raises low power at that edge; n counts edges to done
	task automatic dreq(logic wr, logic [1:0] sz, logic [31:0] ad, logic [31:0] w, int lp);
		@(posedge clk);
		d_req <= 1;
		d_write <= wr;
		d_size <= sz;
		d_addr <= ad;
		d_wdata <= w;
		n = 0;
		do begin
			@(posedge clk);
			if (n + 1 == lp) low_power <= 1;
			#1 n++;
		end while (d_done_q !== 1'b1 && n < 300);
		de = d_err_q;
		rd = d_rdata_q;
		@(posedge clk);
		d_req <= 0;
		low_power <= 0;
	endtask
	task automatic fetch(logic [31:0] ad);
		int m = 0;
		@(posedge clk);
		if_req <= 1;
		if_addr <= ad;
		do begin
			@(posedge clk);
			#1 m++;
		end while (if_valid_q !== 1'b1 && m < 300);
		chk("fetch_data", ew(ad), if_rdata_q);
		@(posedge clk);
		if_req <= 0;
	endtask
	task automatic key(logic [1:0] bk, logic [31:0] kd, logic err);
		@(posedge clk);
		key_wr <= 1;
		key_bank <= bk;
		key_data <= kd;
		@(posedge clk);
		key_wr <= 0;
		#1 chk("key_err", err, key_err_q);
	endtask
	task automatic ctl(logic [1:0] bk, logic pg, logic lk);
		@(posedge clk);
		bank_ctrl_wr <= 1;
		bank_ctrl_bank <= bk;
		bank_ctrl_prog <= pg;
		bank_ctrl_lock <= lk;
		@(posedge clk);
		bank_ctrl_wr <= 0;
		#1;
	endtask
	task automatic acc(logic [4:0] v);
		@(posedge clk);
		access_ctrl_wr <= 1;
		access_ctrl_wdata <= v;
		@(posedge clk);
		access_ctrl_wr <= 0;
		#1 chk("access_ctrl", v, access_ctrl_q);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// budget: the whole run needs a few hundred cycles
	initial begin
		#2_000_000;
		num_errors++;
		$display("watchdog expired");
		final_report;
	end
	initial begin
		void'($urandom(43));
		repeat (2) @(posedge clk);
		rst <= 0;
		#1 chk("access_reset", 5'h10, access_ctrl_q);
		chk("locked_reset", 3'b111, bank_locked_q);
		$display("test reset done");
		wa = 32'($urandom_range(0, 100)) << 5;
		for (int i = 0; i < 9; i++) fetch(wa + 4 * i);
		dreq(0, SZ_WORD, wa + 32'h40, 0, 0);
		chk("data_read", ew(wa + 32'h40), rd);
		$display("test prefetch done");
		// prefetch off is legal only because the bus clock is undivided
		for (int l = 0; l < 8; l++) begin
			acc(5'(l));
			a = $urandom & 32'h0000_0ffc;
			dreq(0, 2'(l % 3), a, 0, 0);
			chk("read_edges", l + 2, n);
			chk("read_data", ew(a), rd);
		end
		acc(5'h0d);
		dreq(0, SZ_WORD, 32'h0000_0088, 0, 0);
		chk("half_cycle_edges", 2, n);
		fetch(32'h0000_0204);
		acc(5'h07);
		dreq(0, SZ_WORD, 32'h0000_0040, 0, 3);
		chk("low_power_err", 1, de);
		acc(5'h10);
		$display("test latency done");
		key(1, SECOND_UNLOCK_WORD, 1);
		key(1, FIRST_UNLOCK_WORD, 1);
		key(0, FIRST_UNLOCK_WORD, 0);
		key(0, SECOND_UNLOCK_WORD, 0);
		key(2, FIRST_UNLOCK_WORD, 0);
		key(2, 32'h1234_5678, 1);
		ctl(1, 1, 0);
		chk("locked", 3'b110, bank_locked_q);
		chk("prog_enabled", 3'b000, prog_enabled_q);
		$display("test unlock done");
		ctl(0, 1, 0);
		wa = 32'h0000_1000 | ($urandom & 32'h0000_03fc);
		wd = $urandom | 32'h1;
		fork
			dreq(1, SZ_WORD, wa, wd, 0);
			fetch(32'h0000_0300);
		join
		put(wa, SZ_WORD, wd);
		chk("busy_seen", 1, busy_seen);
		for (int s = 0; s < 3; s++) begin
			a = wa + 32'h400 + 16 * s + 32'(s == 0) + 32'(2 * (s == 1));
			dreq(1, 2'(s), a, wd, 0);
			put(a, 2'(s), wd);
			dreq(0, 2'(s), a, 0, 0);
			chk("program_read", ew(a), rd);
		end
		dreq(1, SZ_WORD, 32'h0000_0020, wd, 0);
		chk("prog_fail", 3'b001, prog_fail_q);
		@(posedge clk);
		fail_clr <= 3'b001;
		@(posedge clk);
		fail_clr <= 3'b000;
		dreq(1, SZ_WORD, 32'h0000_0020, 0, 0);
		put(32'h0000_0020, SZ_WORD, 0);
		chk("zero_prog_fail", 3'b000, prog_fail_q);
		dreq(0, SZ_WORD, 32'h0000_0020, 0, 0);
		chk("zero_prog_read", ew(32'h0000_0020), rd);
		ctl(0, 0, 1);
		chk("relocked", 3'b111, bank_locked_q);
		dreq(1, SZ_WORD, wa, 0, 0);
		chk("locked_write_err", 1, de);
		key(0, FIRST_UNLOCK_WORD, 0);
		key(0, SECOND_UNLOCK_WORD, 0);
		chk("unlocked_again", 3'b110, bank_locked_q);
		$display("test program done");
		ext_sel <= 1;
		cipher_en <= 1;
		acc(5'h13);
		dreq(0, SZ_BYTE, 32'h0080_0011, 0, 0);
		chk("bank2_byte_err", 1, de);
		dreq(0, SZ_HALF, 32'h0080_0012, 0, 0);
		chk("bank2_half_err", 0, de);
		chk("bank2_half_data", ew(32'h0080_0012), rd);
		dreq(0, SZ_WORD, 32'h00c0_0000, 0, 0);
		chk("no_bank_err", 1, de);
		$display("test bank done");
		final_report;
	end
endmodule

// File: logic/flrpc_ctrl.sv
// flash read path, prefetch buffer, arbiter and program controller
// Functional notes
// R01: two 8-byte prefetch blocks, one read each
// R02: prefetch read starts when a block is free
// R03: prefetch on at reset, off when cleared
// R04: software keeps prefetch on with divided clock
// R05: half-cycle mode selectable, only below 8 MHz
// R06: no half-cycle with prefetch and divided clock
// R07: latency holds read strobes, reset value zero
// R08: data reads win over prefetch reads
// R09: prefetch only for instruction fetches
// R10: byte, half and word reads return data
// R11: reads stall while write or erase runs
// R12: low-power entry aborts every flash operation
// R13: software keeps internal RC oscillator running
// R14: locked after reset, control writes ignored
// R15: unlock needs first then second unlock word
// R16: wrong key sequence locks until reset
// R17: wrong key sequence raises bus error
// R18: lock bit relocks, keys unlock again
// R19: write with program enable starts programming
// R20: busy flag stalls flash reads and writes
// R21: third bank takes word and half only
// R22: serial flash clock is half system clock
// R23: non-erased target skips program, sets fail; all-zero data is still programmed
// R24: controller register writes rejected while busy
// R25: cipher only inside range on third bank
module flrpc_ctrl #(
	parameter int                     NUM_BANKS  = 3,
	parameter logic [flrpc_pkg::WORD_W-1:0] CIPHER_KEY = 32'h5a5a_a5a5  // arbitrary value
) (
	input  wire logic                              clk,
	input  wire logic                              rst,
	input  wire logic                              low_power,
	input  wire logic                              access_ctrl_wr,
	input  wire logic [flrpc_pkg::ACC_W-1:0]       access_ctrl_wdata,
	output logic      [flrpc_pkg::ACC_W-1:0]       access_ctrl_q,
	input  wire logic                              key_wr,
	input  wire logic [flrpc_pkg::BANK_W-1:0]      key_bank,
	input  wire logic [flrpc_pkg::WORD_W-1:0]      key_data,
	input  wire logic                              bank_ctrl_wr,
	input  wire logic [flrpc_pkg::BANK_W-1:0]      bank_ctrl_bank,
	input  wire logic                              bank_ctrl_prog,
	input  wire logic                              bank_ctrl_lock,
	input  wire logic [NUM_BANKS-1:0]              fail_clr,
	input  wire logic                              cipher_en,
	input  wire logic                              ext_sel,
	input  wire logic                              cipher_range_wr,
	input  wire logic [flrpc_pkg::WORD_W-1:0]      cipher_range_wdata,
	output logic                                   key_err_q,
	output logic      [NUM_BANKS-1:0]              bank_locked_q,
	output logic      [NUM_BANKS-1:0]              prog_enabled_q,
	output logic      [NUM_BANKS-1:0]              busy_flag_q,
	output logic      [NUM_BANKS-1:0]              prog_fail_q,
	input  wire logic                              if_req,
	input  wire logic [flrpc_pkg::ADDR_W-1:0]      if_addr,
	output logic                                   if_valid_q,
	output logic      [flrpc_pkg::WORD_W-1:0]      if_rdata_q,
	input  wire logic                              d_req,
	input  wire logic                              d_write,
	input  wire logic [1:0]                        d_size,
	input  wire logic [flrpc_pkg::ADDR_W-1:0]      d_addr,
	input  wire logic [flrpc_pkg::WORD_W-1:0]      d_wdata,
	output logic                                   d_done_q,
	output logic                                   d_err_q,
	output logic      [flrpc_pkg::WORD_W-1:0]      d_rdata_q,
	output logic                                   fl_rd_q,
	output logic                                   fl_prog_q,
	output logic      [flrpc_pkg::ADDR_W-1:0]      fl_addr_q,
	output logic      [flrpc_pkg::WORD_W-1:0]      fl_wdata_q,
	output logic      [1:0]                        fl_wsize_q,
	input  wire logic [flrpc_pkg::BLOCK_W-1:0]     fl_rdata,
	input  wire logic                              fl_prog_done,
	output logic                                   spi_sck_q,
	output logic                                   spi_cs_n_q
);
	import flrpc_pkg::*;

	localparam int TAG_W = ADDR_W - BLK_LSB;

	// bank index of a byte address
	function automatic logic [BANK_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
		return a[BANK_LSB +: BANK_W];
	endfunction

	// byte lanes touched by an access
	function automatic logic [WORD_W-1:0] lane_mask(input logic [1:0] sz, input logic [1:0] a);
		logic [WORD_W-1:0] m;
		m = (sz == SZ_BYTE) ? MASK_BYTE : (sz == SZ_HALF) ? MASK_HALF : MASK_WORD;
		return m << {a, 3'h0};
	endfunction

	// word of a block picked by the address
	function automatic logic [WORD_W-1:0] word_of(input logic [BLOCK_W-1:0] b, input logic [ADDR_W-1:0] a);
		return a[WSEL_BIT] ? b[BLOCK_W-1:WORD_W] : b[WORD_W-1:0];
	endfunction

	flrpc_state_type          state_q;      // sequencer state
	flrpc_src_type            src_q;        // owner of the running read
	logic [CNT_W-1:0]         cnt_q;        // cycles left with strobe held
	logic [ADDR_W-1:0]        op_addr_q;    // address of running operation
	logic [WORD_W-1:0]        op_data_q;    // data to program
	logic [1:0]               op_size_q;    // size to program
	logic [BANK_W-1:0]        op_bank_q;    // bank of running operation
	logic                     fill_slot_q;  // prefetch slot being filled
	logic [WORD_W-1:0]        range_q;      // cipher range, offset limit
	logic [NUM_BANKS-1:0]     stage_q;      // first unlock word seen
	logic [NUM_BANKS-1:0]     dead_q;       // locked until reset
	logic [PF_SLOTS-1:0]      pf_val_q;     // prefetch slot holds data
	logic [TAG_W-1:0]         pf_tag_q [PF_SLOTS];
	logic [BLOCK_W-1:0]       pf_data_q [PF_SLOTS];
	logic [TAG_W-1:0]         pf_next_q;    // next block to prefetch

	// decoded request conditions
	logic                     pf_en, op_busy, d_take, d_bad, d_prog_ok;
	logic                     hit, hit_slot, pf_free, free_slot;
	logic                     pf_miss, idir_take, pf_start, rd_fin, chk_fail, spi_act;
	logic [BLOCK_W-1:0]       rd_block;     // array data after cipher
	logic [WORD_W-1:0]        raw_word, chk_mask, cipher_word;

	assign pf_en     = access_ctrl_q[PF_BIT];
	assign op_busy   = (state_q == ST_CHECK) || (state_q == ST_PROG);
	assign d_take    = d_req && !d_done_q && (state_q == ST_IDLE) && !low_power;
	// byte access on the third bank or a missing bank is refused
	assign d_bad     = (bank_of(d_addr) >= BANK_W'(NUM_BANKS)) ||
	                   ((bank_of(d_addr) == EXT_BANK) && (d_size == SZ_BYTE));  // [R21]
	assign d_prog_ok = !bank_locked_q[bank_of(d_addr)] && prog_enabled_q[bank_of(d_addr)];
	// misses only flush when the sequencer is free, so no fill is lost
	assign pf_miss   = if_req && pf_en && !hit && !if_valid_q && (state_q == ST_IDLE) &&
	                   ((pf_next_q != if_addr[ADDR_W-1:BLK_LSB]) || !pf_free);
	assign idir_take = if_req && !pf_en && !if_valid_q && (state_q == ST_IDLE) && !low_power;
	// data requests always win over a prefetch
	assign pf_start  = (state_q == ST_IDLE) && !low_power && !d_req && !pf_miss && !idir_take &&
	                   pf_en && pf_free;  // [R02] [R08] [R09]
	assign rd_fin    = (state_q == ST_READ) && (cnt_q == '0) && !low_power;
	// cipher is applied only inside the programmed range of the third bank
	assign cipher_word = (cipher_en && (bank_of(op_addr_q) == EXT_BANK) &&
	                      (op_addr_q[BANK_LSB-1:0] < range_q[BANK_LSB-1:0])) ? CIPHER_KEY : ZERO_WORD;  // [R25]
	assign rd_block  = fl_rdata ^ {cipher_word, cipher_word};
	assign raw_word  = word_of(fl_rdata, op_addr_q);
	assign chk_mask  = lane_mask(op_size_q, op_addr_q[1:0]);
	// target not erased and value not all zeros
	assign chk_fail  = ((raw_word & chk_mask) != chk_mask) && ((op_data_q & chk_mask) != ZERO_WORD);  // [R23]
	assign spi_act   = ext_sel && (state_q != ST_IDLE) && (op_bank_q == EXT_BANK);

	// prefetch hit lookup and free slot search
	always_comb begin
		hit       = 1'b0;
		hit_slot  = 1'b0;
		pf_free   = 1'b0;
		free_slot = 1'b0;
		for (int i = PF_SLOTS - 1; i >= 0; i--) begin
			if (pf_val_q[i] && (pf_tag_q[i] == if_addr[ADDR_W-1:BLK_LSB])) begin
				hit      = 1'b1;
				hit_slot = 1'(i);
			end
			if (!pf_val_q[i]) begin
				pf_free   = 1'b1;
				free_slot = 1'(i);
			end
		end
	end

	// access control and cipher range, frozen while busy
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			access_ctrl_q <= ACC_RESET;  // [R03] [R07]
			range_q       <= ZERO_WORD;
		end else if (!op_busy) begin  // [R24]
			if (access_ctrl_wr)
				access_ctrl_q <= access_ctrl_wdata;  // [R05]
			if (cipher_range_wr)
				range_q <= cipher_range_wdata;
		end
	end

	// unlock keys, lock and program enable per bank
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bank_locked_q  <= '1;  // [R14]
			stage_q        <= '0;
			dead_q         <= '0;
			prog_enabled_q <= '0;
			key_err_q      <= 1'b0;
		end else begin
			key_err_q <= 1'b0;
			if (key_wr && !op_busy && (key_bank < BANK_W'(NUM_BANKS)) && bank_locked_q[key_bank]) begin
				if (dead_q[key_bank]) begin
					key_err_q <= 1'b1;  // [R16]
				end else if (!stage_q[key_bank]) begin
					// a bad first word kills the bank until reset
					if (key_data == FIRST_UNLOCK_WORD) begin
						stage_q[key_bank] <= 1'b1;  // [R15]
					end else begin
						dead_q[key_bank] <= 1'b1;  // [R16]
						key_err_q        <= 1'b1;  // [R17]
					end
				end else if (key_data == SECOND_UNLOCK_WORD) begin
					bank_locked_q[key_bank] <= 1'b0;  // [R15]
					stage_q[key_bank]       <= 1'b0;
				end else begin
					dead_q[key_bank] <= 1'b1;  // [R16]
					key_err_q        <= 1'b1;  // [R17]
				end
			end
			// control writes only land on an unlocked, idle bank
			if (bank_ctrl_wr && !op_busy && (bank_ctrl_bank < BANK_W'(NUM_BANKS)) &&
			    !bank_locked_q[bank_ctrl_bank]) begin  // [R14] [R24]
				prog_enabled_q[bank_ctrl_bank] <= bank_ctrl_prog;
				if (bank_ctrl_lock) begin
					bank_locked_q[bank_ctrl_bank]  <= 1'b1;  // [R18]
					prog_enabled_q[bank_ctrl_bank] <= 1'b0;
				end
			end
		end
	end

	// sticky program failure, a new failure beats the clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			prog_fail_q <= '0;
		else
			for (int b = 0; b < NUM_BANKS; b++)
				prog_fail_q[b] <= (prog_fail_q[b] && !fail_clr[b]) ||
				                  ((state_q == ST_CHECK) && (cnt_q == '0) && !low_power &&
				                   chk_fail && (op_bank_q == BANK_W'(b)));  // [R23]
	end

	// sequencer: arbitration, read hold, check and program
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q     <= ST_IDLE;
			src_q       <= SRC_DATA;
			cnt_q       <= '0;
			op_addr_q   <= '0;
			op_data_q   <= ZERO_WORD;
			op_size_q   <= SZ_BYTE;
			op_bank_q   <= '0;
			fill_slot_q <= 1'b0;
			fl_rd_q     <= 1'b0;
			fl_prog_q   <= 1'b0;
			fl_addr_q   <= '0;
			fl_wdata_q  <= ZERO_WORD;
			fl_wsize_q  <= SZ_BYTE;
			d_done_q    <= 1'b0;
			d_err_q     <= 1'b0;
			d_rdata_q   <= ZERO_WORD;
			busy_flag_q <= '0;
		end else begin
			d_done_q <= 1'b0;
			d_err_q  <= 1'b0;
			if (low_power) begin
				// abort whatever runs; a data read or program under way ends in error
				state_q     <= ST_IDLE;  // [R12]
				fl_rd_q     <= 1'b0;
				fl_prog_q   <= 1'b0;
				busy_flag_q <= '0;
				if ((state_q != ST_IDLE) && (src_q == SRC_DATA)) begin
					d_done_q <= 1'b1;
					d_err_q  <= 1'b1;
				end
			end else begin
				unique case (state_q)
					ST_IDLE: begin
						// half-cycle mode answers in the first held cycle
						cnt_q <= access_ctrl_q[HALF_BIT] ? '0 : CNT_W'(access_ctrl_q[LAT_LSB +: LAT_W]);  // [R05] [R07]
						if (d_take) begin
							src_q     <= SRC_DATA;  // [R08]
							op_addr_q <= d_addr;
							op_data_q <= d_wdata;
							op_size_q <= d_size;
							op_bank_q <= bank_of(d_addr);
							fl_addr_q <= {d_addr[ADDR_W-1:BLK_LSB], BLK_LSB'(0)};
							if (d_bad || (d_write && !d_prog_ok)) begin
								d_done_q <= 1'b1;  // [R21]
								d_err_q  <= 1'b1;
							end else if (d_write) begin
								// read the target first to check it is erased
								state_q                     <= ST_CHECK;  // [R19]
								fl_rd_q                     <= 1'b1;
								busy_flag_q[bank_of(d_addr)] <= 1'b1;
							end else begin
								state_q <= ST_READ;  // [R10]
								fl_rd_q <= 1'b1;
							end
						end else if (idir_take) begin
							src_q     <= SRC_IDIR;
							state_q   <= ST_READ;
							fl_rd_q   <= 1'b1;
							op_addr_q <= if_addr;
							op_bank_q <= bank_of(if_addr);
							fl_addr_q <= {if_addr[ADDR_W-1:BLK_LSB], BLK_LSB'(0)};
						end else if (pf_start) begin
							src_q       <= SRC_PF;  // [R02]
							state_q     <= ST_READ;
							fl_rd_q     <= 1'b1;
							fill_slot_q <= free_slot;
							op_addr_q   <= {pf_next_q, BLK_LSB'(0)};
							op_bank_q   <= bank_of({pf_next_q, BLK_LSB'(0)});
							fl_addr_q   <= {pf_next_q, BLK_LSB'(0)};
						end
					end
					ST_READ: begin
						if (cnt_q != '0) begin
							cnt_q <= cnt_q - 1'b1;  // [R07]
						end else begin
							fl_rd_q <= 1'b0;
							state_q <= ST_IDLE;
							if (src_q == SRC_DATA) begin
								d_rdata_q <= word_of(rd_block, op_addr_q);  // [R10]
								d_done_q  <= 1'b1;
							end
						end
					end
					ST_CHECK: begin
						if (cnt_q != '0) begin
							cnt_q <= cnt_q - 1'b1;
						end else begin
							fl_rd_q <= 1'b0;
							if (chk_fail) begin
								state_q     <= ST_IDLE;  // [R23]
								d_done_q    <= 1'b1;
								busy_flag_q <= '0;
							end else begin
								state_q    <= ST_PROG;
								fl_prog_q  <= 1'b1;
								fl_addr_q  <= op_addr_q;
								fl_wdata_q <= op_data_q ^ cipher_word;  // [R25]
								fl_wsize_q <= op_size_q;
							end
						end
					end
					ST_PROG: begin
						// the requesting write is held until the array is done
						if (fl_prog_done) begin
							fl_prog_q   <= 1'b0;  // [R20]
							state_q     <= ST_IDLE;
							d_done_q    <= 1'b1;
							busy_flag_q <= '0;
						end
					end
				endcase
			end
		end
	end

	// prefetch buffer and instruction answers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pf_val_q   <= '0;
			pf_next_q  <= '0;
			if_valid_q <= 1'b0;
			if_rdata_q <= ZERO_WORD;
			for (int i = 0; i < PF_SLOTS; i++) begin
				pf_tag_q[i]  <= '0;
				pf_data_q[i] <= '0;
			end
		end else begin
			if_valid_q <= 1'b0;
			if (!pf_en || low_power) begin
				pf_val_q <= '0;  // [R03] [R12]
			end else if (pf_miss) begin
				// restart the stream at the missed block
				pf_val_q  <= '0;
				pf_next_q <= if_addr[ADDR_W-1:BLK_LSB];
			end else begin
				if (pf_start)
					pf_next_q <= pf_next_q + 1'b1;
				if (rd_fin && (src_q == SRC_PF)) begin
					pf_val_q[fill_slot_q]  <= 1'b1;  // [R01]
					pf_tag_q[fill_slot_q]  <= op_addr_q[ADDR_W-1:BLK_LSB];
					pf_data_q[fill_slot_q] <= rd_block;
				end
				// buffered hits also wait while the array is programmed
				if (if_req && hit && !if_valid_q && !op_busy) begin  // [R11] [R20]
					if_valid_q <= 1'b1;  // [R09]
					if_rdata_q <= word_of(pf_data_q[hit_slot], if_addr);
					if (if_addr[WSEL_BIT])
						pf_val_q[hit_slot] <= 1'b0;  // [R02]
				end
			end
			if (rd_fin && (src_q == SRC_IDIR)) begin
				if_valid_q <= 1'b1;
				if_rdata_q <= word_of(rd_block, op_addr_q);
			end
		end
	end

	// serial flash clock toggles each cycle, giving half the system clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			spi_sck_q  <= 1'b0;
			spi_cs_n_q <= 1'b1;
		end else begin
			spi_sck_q  <= spi_act ? !spi_sck_q : 1'b0;  // [R22]
			spi_cs_n_q <= !spi_act;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_key_go;
		key_wr && !op_busy && (key_bank < BANK_W'(NUM_BANKS)) && bank_locked_q[key_bank] && !dead_q[key_bank];
	endsequence
	sequence s_hold_two;
		($rose(fl_rd_q) && (cnt_q == CNT_W'(1)) && !low_power) ##1 !low_power;
	endsequence

	unlock_pair_a: assert property ((s_key_go and (stage_q[key_bank] && key_data == SECOND_UNLOCK_WORD)) |=>
		!bank_locked_q[$past(key_bank)])  // [R15]
		else $error("correct key pair did not unlock");
	bad_key_a: assert property ((s_key_go and (!stage_q[key_bank] && key_data != FIRST_UNLOCK_WORD)) |=>
		key_err_q && dead_q[$past(key_bank)])  // [R16] [R17]
		else $error("wrong first key not refused");
	locked_ctrl_a: assert property (bank_ctrl_wr && (bank_ctrl_bank < BANK_W'(NUM_BANKS)) &&
		bank_locked_q[bank_ctrl_bank] |=> $stable(prog_enabled_q))  // [R14]
		else $error("control write landed on locked bank");
	busy_reg_a: assert property (op_busy && access_ctrl_wr |=> $stable(access_ctrl_q))  // [R24]
		else $error("register written while busy");
	data_first_a: assert property (d_take |=> src_q == SRC_DATA)  // [R08]
		else $error("prefetch started over data read");
	hold_two_a: assert property (s_hold_two |=> !fl_rd_q && state_q == ST_IDLE)  // [R07]
		else $error("read strobe hold length wrong");
	lp_abort_a: assert property (low_power |=> state_q == ST_IDLE && !fl_rd_q && !fl_prog_q)  // [R12]
		else $error("low power did not abort");
	byte_third_a: assert property (d_take && bank_of(d_addr) == EXT_BANK && d_size == SZ_BYTE |=>
		d_done_q && d_err_q)  // [R21]
		else $error("byte access on third bank accepted");
	stall_read_a: assert property (op_busy |=> !if_valid_q)  // [R20]
		else $error("fetch answered during programming");
	prog_start_a: assert property (d_take && d_write && !d_bad && d_prog_ok |=> state_q == ST_CHECK ##0 fl_rd_q)  // [R19]
		else $error("enabled write did not start programming");
	fail_skip_a: assert property (state_q == ST_CHECK && cnt_q == '0 && chk_fail && !low_power |=>
		!fl_prog_q && prog_fail_q[$past(op_bank_q)])  // [R23]
		else $error("non-erased target was programmed");
	sck_half_a: assert property (spi_act ##1 spi_act |=> spi_sck_q != $past(spi_sck_q))  // [R22]
		else $error("serial clock not toggling");
	pf_off_a: assert property (access_ctrl_wr && !op_busy && !access_ctrl_wdata[PF_BIT] |=> ##1 pf_val_q == '0)  // [R03]
		else $error("prefetch buffer kept data when disabled");
endmodule

// File: logic/flrpc_pkg.sv
// package: constants and types of the flash read and program controller
package flrpc_pkg;
	localparam int ADDR_W   = 32;  // byte address width
	localparam int WORD_W   = 32;  // bus word
	localparam int BLOCK_W  = 64;  // one 8-byte array read
	localparam int BLK_LSB  = 3;   // byte offset bits inside a block
	localparam int WSEL_BIT = 2;   // picks the word inside a block
	localparam int BANK_LSB = 22;  // 4 MB per bank
	localparam int BANK_W   = 2;   // bank index width
	localparam int PF_SLOTS = 2;   // prefetch blocks
	localparam int CNT_W    = 4;   // read hold counter
	// access control register layout
	localparam int ACC_W    = 5;
	localparam int LAT_LSB  = 0;
	localparam int LAT_W    = 3;
	localparam int HALF_BIT = 3;
	localparam int PF_BIT   = 4;
	localparam logic [ACC_W-1:0] ACC_RESET = 5'h10;  // prefetch on, latency 0
	// unlock words
	localparam logic [WORD_W-1:0] FIRST_UNLOCK_WORD  = 32'h4567_0123;
	localparam logic [WORD_W-1:0] SECOND_UNLOCK_WORD = 32'hcdef_89ab;
	localparam logic [WORD_W-1:0] ZERO_WORD          = 32'h0000_0000;
	localparam logic [BANK_W-1:0] EXT_BANK = 2'h2;  // third bank
	// access sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [WORD_W-1:0] MASK_BYTE = 32'h0000_00ff;
	localparam logic [WORD_W-1:0] MASK_HALF = 32'h0000_ffff;
	localparam logic [WORD_W-1:0] MASK_WORD = 32'hffff_ffff;
	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_CHECK, ST_PROG} flrpc_state_type;
	typedef enum logic [1:0] {SRC_DATA, SRC_IDIR, SRC_PF} flrpc_src_type;
endpackage
